// ---- core/vrc_top.sv ----
// Notes on behaviour
// R1 - bit 7 of reference_control powers the ladder on when 1 and fully off when 0.
// R2 - bit 6 connects the reference to port pin two when set and disconnects it when clear.
// R3 - bit 5 picks the low range when 1 and the high range when 0.
// R4 - bits 3 to 0 are an unsigned tap code from 0 to 15 picking one of sixteen levels.
// R5 - in the low range the chosen tap gives code over 24 of the supply.
// R6 - in the high range the chosen tap gives a quarter of the supply plus code over 32.
// R7 - bit 4 stores nothing and always reads zero.
// R8 - every reset clears power, pin enable, range (to high) and the tap code.
// R9 - waking from sleep leaves reference_control untouched.
// R10 - the pin switch closes only while the pin direction bit and the pin enable are both set.
// R11 - the comparator mode never gates power, range or tap selection.
// R12 - software should switch the ladder off before sleep to save current.
// R13 - reference_control sits at index 9Fh and its bits read zero after any reset.
// R14 - software waits out the settling time after a tap or range change.
// R15 - comparator mode 010 routes the reference to both non-inverting comparator inputs.
// R16 - a write updates the ladder outputs on its completing edge and a read returns stored bits.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module vrc_top (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [vrc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [vrc_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [vrc_pkg::STRB_W-1:0]  pstrb,
    output logic                             pready,
    output logic                             pslverr,
    output logic [vrc_pkg::DATA_W-1:0]       prdata,
    // neighbouring control bits
    input  wire logic                        port_direction_two,
    input  wire logic [2:0]                  comparator_mode_field,
    // analog ladder and pin switch
    output logic                             ladder_power_enable,
    output logic                             ladder_low_range,
    output logic [vrc_pkg::TAP_W-1:0]        ladder_tap_code,
    output logic [vrc_pkg::POS_W-1:0]        ladder_tap_position,
    output logic                             pin_switch_close,
    output logic                             comparator_ref_route
);

    vrc_pkg::vrc_state_t       s_r;
    vrc_pkg::vrc_state_t       s_nxt;
    logic                      hit_ctrl;
    logic                      hit_status;
    logic                      mapped;
    logic [vrc_pkg::POS_W-1:0] pos_nxt;
    logic [vrc_pkg::DATA_W-1:0] read_word;
    logic [vrc_pkg::DATA_W-1:0] status_word;

    vrc_apb_decode u_decode (
        .paddr      (paddr),
        .hit_ctrl   (hit_ctrl),
        .hit_status (hit_status),
        .mapped     (mapped)
    );

    vrc_ladder_map u_map (
        .ctrl    (s_nxt.ctrl),
        .tap_pos (pos_nxt)
    );

    // status view of the block outputs
    always_comb
    begin
        status_word = '0;
        status_word[vrc_pkg::ST_POWER_BIT] = s_r.ctrl.power;
        status_word[vrc_pkg::ST_PIN_BIT] = s_r.pin_switch;
        status_word[vrc_pkg::ST_ROUTE_BIT] = s_r.comp_route;
        status_word[vrc_pkg::ST_RANGE_BIT] = s_r.ctrl.low_range;
        status_word[vrc_pkg::ST_POS_LSB +: vrc_pkg::POS_W] = s_r.tap_pos;
    end

    // read mux, unimplemented and upper bits read zero
    always_comb
    begin
        read_word = '0;
        if (hit_ctrl)
        begin
            read_word[7:0] = vrc_pkg::ctrl_to_byte(s_r.ctrl); // [R7] [R16]
        end
        else if (hit_status)
        begin
            read_word = status_word;
        end
    end

    always_comb
    begin
        s_nxt = s_r;
        case (s_r.phase)
            vrc_pkg::VRC_PH_IDLE:
            begin
                if (psel && !penable)
                begin
                    s_nxt.phase = vrc_pkg::VRC_PH_ACCESS;
                    s_nxt.rsp.pready = 1'b1;
                    s_nxt.rsp.pslverr = !mapped;
                    s_nxt.rsp.prdata = pwrite ? '0 : read_word;
                end
            end
            vrc_pkg::VRC_PH_ACCESS:
            begin
                if (psel && penable)
                begin
                    // write lands on the completing edge
                    if (pwrite && hit_ctrl && pstrb[0])
                    begin
                        s_nxt.ctrl = vrc_pkg::byte_to_ctrl(pwdata[7:0]); // [R1] [R2] [R3] [R4] [R7] [R16]
                    end
                    s_nxt.phase = vrc_pkg::VRC_PH_IDLE;
                    s_nxt.rsp = '0;
                end
            end
            default:
            begin
                s_nxt = vrc_pkg::STATE_RESET;
            end
        endcase
        // only reset or an unknown phase clears the control, a wake from sleep does not
        if (!rst_n)
        begin
            s_nxt = vrc_pkg::STATE_RESET; // [R8] [R9] [R13]
        end
        // no comparator state enters the ladder control
        s_nxt.pin_switch = s_nxt.ctrl.pin_oe & port_direction_two; // [R10] [R11]
        s_nxt.comp_route = (comparator_mode_field == vrc_pkg::COMP_MODE_INTERNAL_REF); // [R15]
        s_nxt.tap_pos = pos_nxt; // [R5] [R6]
        if (!rst_n)
        begin
            s_nxt.pin_switch = 1'b0;
            s_nxt.comp_route = 1'b0;
            s_nxt.tap_pos = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        s_r <= s_nxt;
    end

    assign pready = s_r.rsp.pready;
    assign pslverr = s_r.rsp.pslverr;
    assign prdata = s_r.rsp.prdata;
    assign ladder_power_enable = s_r.ctrl.power; // [R1]
    assign ladder_low_range = s_r.ctrl.low_range; // [R3]
    assign ladder_tap_code = s_r.ctrl.tap; // [R4]
    assign ladder_tap_position = s_r.tap_pos;
    assign pin_switch_close = s_r.pin_switch; // [R2]
    assign comparator_ref_route = s_r.comp_route;

endmodule

`default_nettype wire

// ---- core/vrc_pkg.sv ----
package vrc_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;

    // register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] REF_CTRL_INDEX = 12'h09f;
    localparam logic [ADDR_W-1:0] STATUS_INDEX   = 12'h0a0;
    localparam logic [ADDR_W-1:0] REF_CTRL_ADDR  = {REF_CTRL_INDEX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR    = {STATUS_INDEX[ADDR_W-3:0], 2'b00};

    // reference_control field positions
    localparam int unsigned POWER_BIT  = 7;
    localparam int unsigned PIN_OE_BIT = 6;
    localparam int unsigned RANGE_BIT  = 5;
    localparam int unsigned TAP_MSB    = 3;
    localparam int unsigned TAP_LSB    = 0;
    localparam int unsigned TAP_W      = TAP_MSB - TAP_LSB + 1;
    localparam logic [7:0]  REF_CTRL_RESET = 8'h00;

    // status field positions
    localparam int unsigned ST_POWER_BIT = 0;
    localparam int unsigned ST_PIN_BIT   = 1;
    localparam int unsigned ST_ROUTE_BIT = 2;
    localparam int unsigned ST_RANGE_BIT = 3;
    localparam int unsigned ST_POS_LSB   = 4;

    // comparator mode that takes the internal reference
    localparam logic [2:0] COMP_MODE_INTERNAL_REF = 3'b010;

    // ladder in units of 1/96 of the supply
    localparam int unsigned POS_W       = 7;
    localparam int unsigned LADDER_UNITS = 96;
    localparam int unsigned LOW_DIV      = 24;
    localparam int unsigned HIGH_DIV     = 32;
    localparam int unsigned HIGH_FRAC    = 4;
    localparam logic [POS_W-1:0] LOW_STEP  = POS_W'(LADDER_UNITS / LOW_DIV);
    localparam logic [POS_W-1:0] HIGH_STEP = POS_W'(LADDER_UNITS / HIGH_DIV);
    localparam logic [POS_W-1:0] HIGH_BASE = POS_W'(LADDER_UNITS / HIGH_FRAC);

    typedef struct packed {
        logic             power;
        logic             pin_oe;
        logic             low_range;
        logic [TAP_W-1:0] tap;
    } vrc_ctrl_t;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } vrc_apb_rsp_t;

    typedef enum logic [1:0] {
        VRC_PH_IDLE   = 2'b00,
        VRC_PH_ACCESS = 2'b01
    } vrc_phase_t;

    typedef struct packed {
        vrc_phase_t       phase;
        vrc_apb_rsp_t     rsp;
        vrc_ctrl_t        ctrl;
        logic             pin_switch;
        logic             comp_route;
        logic [POS_W-1:0] tap_pos;
    } vrc_state_t;

    localparam vrc_ctrl_t CTRL_RESET = '{
        power:     REF_CTRL_RESET[POWER_BIT],
        pin_oe:    REF_CTRL_RESET[PIN_OE_BIT],
        low_range: REF_CTRL_RESET[RANGE_BIT],
        tap:       REF_CTRL_RESET[TAP_MSB:TAP_LSB]
    };

    localparam vrc_state_t STATE_RESET = '{
        phase:      VRC_PH_IDLE,
        rsp:        '0,
        ctrl:       CTRL_RESET,
        pin_switch: 1'b0,
        comp_route: 1'b0,
        tap_pos:    '0
    };

    // bit 4 is never stored and always reads zero
    function automatic logic [7:0] ctrl_to_byte(input vrc_ctrl_t c);
        logic [7:0] b;
        b = 8'h00;
        b[POWER_BIT] = c.power;
        b[PIN_OE_BIT] = c.pin_oe;
        b[RANGE_BIT] = c.low_range;
        b[TAP_MSB:TAP_LSB] = c.tap;
        return b;
    endfunction

    function automatic vrc_ctrl_t byte_to_ctrl(input logic [7:0] b);
        vrc_ctrl_t c;
        c.power = b[POWER_BIT];
        c.pin_oe = b[PIN_OE_BIT];
        c.low_range = b[RANGE_BIT];
        c.tap = b[TAP_MSB:TAP_LSB];
        return c;
    endfunction

endpackage

// ---- core/vrc_apb_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

module vrc_apb_decode (
    // address
    input  wire logic [vrc_pkg::ADDR_W-1:0] paddr,
    // decode
    output logic                            hit_ctrl,
    output logic                            hit_status,
    output logic                            mapped
);

    always_comb
    begin
        hit_ctrl = (paddr == vrc_pkg::REF_CTRL_ADDR);
        hit_status = (paddr == vrc_pkg::STATUS_ADDR);
        mapped = hit_ctrl | hit_status;
    end

endmodule

`default_nettype wire

// ---- core/vrc_ladder_map.sv ----
`timescale 1ns/1ps
`default_nettype none

module vrc_ladder_map (
    // control
    input  wire vrc_pkg::vrc_ctrl_t        ctrl,
    // ladder
    output logic [vrc_pkg::POS_W-1:0]      tap_pos
);

    // tap position in 1/96 supply units
    always_comb
    begin
        if (ctrl.low_range)
        begin
            tap_pos = vrc_pkg::POS_W'(ctrl.tap) * vrc_pkg::LOW_STEP; // [R5]
        end
        else
        begin
            tap_pos = vrc_pkg::HIGH_BASE + vrc_pkg::POS_W'(ctrl.tap) * vrc_pkg::HIGH_STEP; // [R6]
        end
    end

endmodule

`default_nettype wire

// ---- tb/vrc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module vrc_props (
    // clock
    input wire logic        clock,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // side inputs
    input wire logic        port_direction_two,
    input wire logic [2:0]  comparator_mode_field,
    // ladder
    input wire logic        ladder_power_enable,
    input wire logic        ladder_low_range,
    input wire logic [3:0]  ladder_tap_code,
    input wire logic [6:0]  ladder_tap_position,
    input wire logic        pin_switch_close,
    input wire logic        comparator_ref_route
);
    logic ctrl_wr;
    assign ctrl_wr = psel && penable && pready && pwrite && pstrb[0]
                     && paddr == vrc_pkg::REF_CTRL_ADDR;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wr_s;
        ctrl_wr;
    endsequence
    setup_ready_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("no single ready pulse");
    ctrl_write_a: assert property (wr_s |=> ladder_power_enable == $past(pwdata[7])
        && ladder_low_range == $past(pwdata[5]) && ladder_tap_code == $past(pwdata[3:0]))
        else $error("write not applied");
    ctrl_hold_a: assert property (!ctrl_wr |=> $stable({ladder_power_enable,
        ladder_low_range, ladder_tap_code})) else $error("control changed");
    tap_level_a: assert property ($past(rst_n) |-> ladder_tap_position == (ladder_low_range
        ? 7'(4 * ladder_tap_code) : 7'(24 + 3 * ladder_tap_code))) else $error("bad tap");
    pin_switch_a: assert property (pin_switch_close |-> $past(port_direction_two))
        else $error("pin switch without direction");
    comp_route_a: assert property ($past(rst_n) |-> comparator_ref_route ==
        ($past(comparator_mode_field) == 3'b010)) else $error("bad route");
    error_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    ctrl_read_a: assert property (pready && paddr == vrc_pkg::REF_CTRL_ADDR |->
        prdata[31:8] == 24'h0 && !prdata[4]) else $error("bad read bits");
    reset_clear_a: assert property ($rose(rst_n) |-> !ladder_power_enable && !ladder_low_range
        && ladder_tap_code == 4'h0 && !pin_switch_close) else $error("reset not cleared");
endmodule
bind vrc_top vrc_props u_props (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .pslverr, .prdata, .port_direction_two, .comparator_mode_field,
    .ladder_power_enable, .ladder_low_range, .ladder_tap_code, .ladder_tap_position,
    .pin_switch_close, .comparator_ref_route);
`default_nettype wire

// ---- tb/vrc_ladder_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vrc_ladder_model #(parameter int SETTLE = 3) (
    // ladder controls
    input wire logic       clock,
    input wire logic       ladder_power_enable,
    input wire logic [6:0] ladder_tap_position,
    input wire logic       pin_switch_close,
    // pin level in 1/96 supply units
    output logic [6:0]     pin_level,
    output logic           settled
);
    int         wait_r = 0;
    logic [6:0] last_r = 7'h00;
    always @(posedge clock)
    begin
        wait_r <= (ladder_tap_position != last_r) ? SETTLE : (wait_r != 0 ? wait_r - 1 : 0);
        last_r <= ladder_tap_position;
    end
    assign settled = (wait_r == 0);
    // a released pin floats: show the inverse, never a stale level
    assign pin_level = (ladder_power_enable && pin_switch_close) ? last_r : ~last_r;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, port_direction_two;
    logic        ladder_power_enable, ladder_low_range, pin_switch_close, comparator_ref_route;
    logic        settled;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [3:0]  pstrb, ladder_tap_code;
    logic [2:0]  comparator_mode_field;
    logic [6:0]  ladder_tap_position, pin_level;
    logic [32:0] exp_q[$];
    int          fails, checks;
    localparam logic [11:0] CTRL = vrc_pkg::REF_CTRL_ADDR;
    localparam logic [11:0] STAT = vrc_pkg::STATUS_ADDR;
    vrc_top uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .pslverr, .prdata, .port_direction_two, .comparator_mode_field, .ladder_power_enable,
        .ladder_low_range, .ladder_tap_code, .ladder_tap_position, .pin_switch_close,
        .comparator_ref_route);
    vrc_ladder_model model (.clock, .ladder_power_enable, .ladder_tap_position,
        .pin_switch_close, .pin_level, .settled);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [32:0] stat(input logic [7:0] v, input logic d, input logic [2:0] m);
        logic [6:0] p;
        p = v[5] ? 7'(4 * v[3:0]) : 7'(24 + 3 * v[3:0]);
        return {22'h0, p, v[5], m == 3'b010, v[6] & d, v[7]};
    endfunction
    task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        // the wait for the reply ends on pready; only the watchdog ends a wait that never gets one
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock)
        if (pready === 1'b1 && exp_q.size() > 0)
            chk("apb reply", {pslverr, prdata}, exp_q.pop_front());
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        #100000;
        fails++;
        summarize;
    end
    initial
    begin
        logic [7:0]  v;
        logic [31:0] r;
        {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {port_direction_two, comparator_mode_field, fails, checks} = '0;
        seed = 32'd12704;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, CTRL, 32'h0, 4'h0, 33'h0);
        apb(1'b0, STAT, 32'h0, 4'h0, stat(8'h00, 1'b0, 3'b000));
        for (int i = 0; i < 32; i++)
        begin
            r = rnd();
            v = {r[7:6], i[4], r[4], i[3:0]};
            port_direction_two <= r[8];
            comparator_mode_field <= i[2:0];
            apb(1'b1, CTRL, {r[31:8], v}, {r[11:9], 1'b1}, 33'h0);
            apb(1'b0, CTRL, 32'h0, 4'h0, {25'h0, v & 8'hef});
            apb(1'b0, STAT, 32'h0, 4'h0, stat(v, r[8], i[2:0]));
        end
        apb(1'b1, CTRL, 32'hff, 4'he, 33'h0);
        apb(1'b1, STAT, 32'hffffffff, 4'hf, 33'h0);
        apb(1'b1, 12'h010, 32'hff, 4'hf, {1'b1, 32'h0});
        apb(1'b0, CTRL + 12'h001, 32'h0, 4'h0, {1'b1, 32'h0});
        apb(1'b0, CTRL, 32'h0, 4'h0, {25'h0, v & 8'hef});
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, CTRL, 32'h0, 4'h0, 33'h0);
        port_direction_two <= 1'b1;
        apb(1'b1, CTRL, 32'hc5, 4'h1, 33'h0);
        repeat (8) @(posedge clock);
        chk("pin level", {25'h0, settled, pin_level}, {25'h0, 1'b1, 7'd39});
        apb(1'b1, CTRL, 32'h0, 4'h1, 33'h0);
        summarize;
    end
endmodule
`default_nettype wire
